/* File: include/aaa_pkg.sv */
// Constants for the alarm and alert aggregator: register map, fields, resets, state codes.
// Assumes a 32-bit APB slave with a 12-bit byte address and one word per register.
package aaa_pkg;
  // Register byte offsets
  localparam logic [11:0] AAA_OFF_CTRL = 12'h000;
  localparam logic [11:0] AAA_OFF_LIVE = 12'h004;
  localparam logic [11:0] AAA_OFF_STICKY = 12'h008;
  localparam logic [11:0] AAA_OFF_STICKY_CLR = 12'h00C;
  localparam logic [11:0] AAA_OFF_CONTRIB = 12'h010;
  localparam logic [11:0] AAA_OFF_BLK_STICKY = 12'h014;
  localparam logic [11:0] AAA_OFF_BLK_CLR = 12'h018;
  localparam logic [11:0] AAA_OFF_BLK_EN = 12'h01C;
  localparam logic [11:0] AAA_OFF_PIN_EN = 12'h020;
  localparam logic [11:0] AAA_OFF_PIN_OD = 12'h024;
  localparam logic [11:0] AAA_OFF_PIN_PULL = 12'h028;
  localparam logic [11:0] AAA_OFF_PIN_INV = 12'h02C;
  localparam logic [11:0] AAA_OFF_PIN_MODE = 12'h030;
  localparam logic [11:0] AAA_OFF_GP_OUT = 12'h034;
  localparam logic [11:0] AAA_OFF_GP_IN = 12'h038;
  localparam logic [11:0] AAA_OFF_PLL_STATE = 12'h03C;
  localparam logic [11:0] AAA_OFF_PIN_SEL0 = 12'h040;
  // Control register fields
  localparam int AAA_CTRL_GEN_BIT = 0;
  localparam int AAA_CTRL_SUPPLY_BIT = 1;
  localparam int AAA_CTRL_ALERT_INV_BIT = 2;
  localparam int AAA_CTRL_ALERT_EN_BIT = 3;
  localparam int AAA_CTRL_ALERT_PIN_LSB = 8;
  localparam int AAA_PIN_IDX_W = 4;
  localparam int AAA_ALM_IDX_W = 5;
  // Reset values
  localparam logic [31:0] AAA_CTRL_RST = 32'h0000_0000;
  localparam logic AAA_PULL_UP_RST = 1'b1;
  // Alarm layout per source block
  localparam int AAA_ALM_PER_REF = 3;
  localparam int AAA_ALM_PER_PLL = 2;
  // Loop state-machine codes as reported on the state inputs
  localparam int AAA_PLL_ST_W = 4;
  localparam logic [3:0] AAA_PLL_ST_LOCKED = 4'h3;
  localparam logic [3:0] AAA_PLL_ST_HOLDOVER = 4'h5;
  // Per-pin operating modes handled here
  typedef enum logic [1:0] {AAA_MODE_IN, AAA_MODE_OUT, AAA_MODE_ALARM, AAA_MODE_RSVD} aaa_mode_t;
endpackage

/* File: core/aaa_core.sv */
// Alarm status, sticky capture and alert aggregation with per-pin general purpose pin control.
// Assumes alarm sources and loop states arrive synchronous to clk; pins are asynchronous.
//
// Function
// R1: One global bit selects the supply level used by all pins.
// R2: Each pin has its own register enable bit.
// R3: Enabled output pins drive open-drain or push-pull per pin setting.
// R4: Each pin has pull-up or pull-down select; pull-up after reset.
// R5: Live status bit per alarm reads the present alarm state.
// R6: Sticky bit sets on every change of its live bit.
// R7: Sticky bits clear only by host write to their clear control.
// R8: Single-alarm pin shows live or sticky state, high active, invertible.
// R9: Alert output derives only from sticky bits.
// R10: One pin selectable as Alert, per-alarm contribution enables, Alert inversion.
// R11: Holdover live alarm asserted while loop is in holdover.
// R12: Locked live alarm needs both loop and system analog loop locked.
// R13: Every alarm has live, sticky, clear control and effect enables.
// R14: Host may clear any single sticky bit, any subset, or all.
// R15: Each source block has its own sticky, clear, enable; loops report state.
// R16: Alarm output stays until both alarm and block sticky bits clear.
// R17: Host should clear alarm sticky bits before block sticky bits.
// R18: Pin may lag sticky clearing; host must not edge-trigger on it.
// R19: One global alarm enable blocks all new alarms.
// R20: Loop sticky alarms raise on state entry; live follows current state.
// R21: Sources: reference monitors and every loop including the system loop.
// R22: Alert is OR of enabled sticky bits, gated globally, optionally inverted.
`timescale 1ns/1ps
module aaa_core
  import aaa_pkg::*;
#(
  parameter int NUM_REF = 4, // Reference monitors
  parameter int NUM_PLL = 3, // Digital loops, the last one is the system_digital_loop
  parameter int NUM_PIN = 8 // General purpose pins
)(
  input wire logic clk, // System clock, 40 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [11:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [NUM_REF-1:0] ref_freq_alm, // Frequency offset limit alarms
  input wire logic [NUM_REF-1:0] ref_los_alm, // Loss of signal alarms
  input wire logic [NUM_REF-1:0] ref_act_alm, // Activity alarms
  input wire logic [NUM_PLL*AAA_PLL_ST_W-1:0] pll_state, // Loop state codes, 4 bits each
  input wire logic sys_apll_locked, // System analog loop is locked
  input wire logic [NUM_PIN-1:0] gpio_i, // Pin levels from pads
  output logic [NUM_PIN-1:0] gpio_o, // Pin output levels
  output logic [NUM_PIN-1:0] gpio_oe, // Pin output enables, high drives
  output logic [NUM_PIN-1:0] gpio_pullup, // Bias select, high pull-up
  output logic gpio_supply_sel // Pin supply level select
);
  localparam int NUM_ALM = AAA_ALM_PER_REF * NUM_REF + AAA_ALM_PER_PLL * NUM_PLL;
  localparam int NUM_BLK = NUM_REF + NUM_PLL;
  localparam int REF_ALMS = AAA_ALM_PER_REF * NUM_REF;

  // Source block that owns alarm i
  function automatic int blk_of(input int i);
    if (i < REF_ALMS)
    begin
      return i / AAA_ALM_PER_REF;
    end
    return NUM_REF + (i - REF_ALMS) / AAA_ALM_PER_PLL;
  endfunction

  // Loop alarms are shown sticky on a pin, monitor alarms live
  function automatic logic is_sticky_kind(input int i);
    return (i >= REF_ALMS);
  endfunction

  logic [31:0] ctrl_r;
  logic [NUM_ALM-1:0] live_r, live_prev_r, sticky_r, contrib_r, alm_chg;
  logic [NUM_ALM-1:0] live_nxt, sticky_set, sticky_clr;
  logic [NUM_BLK-1:0] blk_sticky_r, blk_en_r, blk_set, blk_clr;
  logic [NUM_PIN-1:0] pin_en_r, pin_od_r, pin_inv_r, gp_out_r, gp_in_r;
  logic [NUM_PIN-1:0] sync1_r, sync2_r, sync3_r;
  logic [2*NUM_PIN-1:0] pin_mode_r;
  logic [AAA_ALM_IDX_W-1:0] pin_sel_r [NUM_PIN];
  logic [NUM_PIN-1:0] pin_val, pin_drv, gpio_o_nxt, gpio_oe_nxt;
  logic alert_raw, alert_raw_r, gen_en;
  logic wr_en, rd_en, pready_r, pslverr_r, hit;
  logic [31:0] prdata_r, rd_nxt;

  assign gen_en = ctrl_r[AAA_CTRL_GEN_BIT];
  // A transfer completes on the second access cycle, pready comes from a flop
  assign wr_en = psel && penable && pwrite && pready_r;
  assign rd_en = psel && penable && !pwrite && !pready_r;

  // True when this cycle completes a write to offset off
  function automatic logic wr_hit(input logic [11:0] off);
    return wr_en && (paddr == off);
  endfunction

  // Live bits from the sources, one cycle of registering
  always_comb
  begin
    live_nxt = '0;
    for (int r = 0; r < NUM_REF; r++)
    begin
      live_nxt[AAA_ALM_PER_REF*r] = ref_freq_alm[r];
      live_nxt[AAA_ALM_PER_REF*r+1] = ref_los_alm[r];
      live_nxt[AAA_ALM_PER_REF*r+2] = ref_act_alm[r];
    end
    for (int k = 0; k < NUM_PLL; k++)
    begin
      // Holdover follows the state directly [R11] [R20]
      live_nxt[REF_ALMS+AAA_ALM_PER_PLL*k] =
        (pll_state[AAA_PLL_ST_W*k +: AAA_PLL_ST_W] == AAA_PLL_ST_HOLDOVER);
      // Locked needs the system analog loop too [R12] [R20]
      live_nxt[REF_ALMS+AAA_ALM_PER_PLL*k+1] =
        (pll_state[AAA_PLL_ST_W*k +: AAA_PLL_ST_W] == AAA_PLL_ST_LOCKED) && sys_apll_locked;
    end
  end

  // Live and previous-live registers [R5] [R21]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      live_r <= '0;
      live_prev_r <= '0;
    end
    else
    begin
      live_r <= live_nxt;
      live_prev_r <= live_r;
    end
  end

  // Either edge of a live bit is a new event, blocked while alarms are disabled
  assign alm_chg = live_r ^ live_prev_r;
  assign sticky_set = alm_chg & {NUM_ALM{gen_en}}; // [R6] [R19]
  assign sticky_clr = wr_hit(AAA_OFF_STICKY_CLR) ? pwdata[NUM_ALM-1:0] : '0; // [R14]

  // Sticky alarm bits; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sticky_r <= '0;
    end
    else
    begin
      sticky_r <= (sticky_r & ~sticky_clr) | sticky_set; // [R7] [R13]
    end
  end

  // Block bits follow any pending alarm of the block, so clearing order matters
  always_comb
  begin
    blk_set = '0;
    for (int i = 0; i < NUM_ALM; i++)
    begin
      if (sticky_r[i] || sticky_set[i])
      begin
        blk_set[blk_of(i)] = 1'b1; // [R15] [R17]
      end
    end
  end
  assign blk_clr = wr_hit(AAA_OFF_BLK_CLR) ? pwdata[NUM_BLK-1:0] : '0;

  // Block-level sticky bits
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      blk_sticky_r <= '0;
    end
    else
    begin
      blk_sticky_r <= (blk_sticky_r & ~blk_clr) | blk_set; // [R15] [R7]
    end
  end

  // Alert sees sticky state only; with the block enable set it holds until both levels are clear
  assign alert_raw = gen_en && ((|(sticky_r & contrib_r)) || (|(blk_sticky_r & blk_en_r))); // [R9] [R16] [R22]

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      alert_raw_r <= 1'b0;
    end
    else
    begin
      alert_raw_r <= alert_raw;
    end
  end

  // Control, enable and selection registers written by software
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= AAA_CTRL_RST;
      contrib_r <= '0;
      blk_en_r <= '0;
    end
    else
    begin
      if (wr_hit(AAA_OFF_CTRL))
      begin
        ctrl_r <= pwdata; // [R1] [R10] [R19]
      end
      if (wr_hit(AAA_OFF_CONTRIB))
      begin
        contrib_r <= pwdata[NUM_ALM-1:0]; // [R10] [R13]
      end
      if (wr_hit(AAA_OFF_BLK_EN))
      begin
        blk_en_r <= pwdata[NUM_BLK-1:0]; // [R15]
      end
    end
  end

  // Per-pin configuration
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_en_r <= '0;
      pin_od_r <= '0;
      gpio_pullup <= {NUM_PIN{AAA_PULL_UP_RST}};
      pin_inv_r <= '0;
      pin_mode_r <= '0;
      gp_out_r <= '0;
      for (int p = 0; p < NUM_PIN; p++)
      begin
        pin_sel_r[p] <= '0;
      end
    end
    else
    begin
      if (wr_hit(AAA_OFF_PIN_EN))
      begin
        pin_en_r <= pwdata[NUM_PIN-1:0]; // [R2]
      end
      if (wr_hit(AAA_OFF_PIN_OD))
      begin
        pin_od_r <= pwdata[NUM_PIN-1:0]; // [R3]
      end
      if (wr_hit(AAA_OFF_PIN_PULL))
      begin
        gpio_pullup <= pwdata[NUM_PIN-1:0]; // [R4]
      end
      if (wr_hit(AAA_OFF_PIN_INV))
      begin
        pin_inv_r <= pwdata[NUM_PIN-1:0]; // [R8]
      end
      if (wr_hit(AAA_OFF_PIN_MODE))
      begin
        pin_mode_r <= pwdata[2*NUM_PIN-1:0];
      end
      if (wr_hit(AAA_OFF_GP_OUT))
      begin
        gp_out_r <= pwdata[NUM_PIN-1:0];
      end
      for (int p = 0; p < NUM_PIN; p++)
      begin
        if (wr_hit(AAA_OFF_PIN_SEL0 + 12'(4 * p)))
        begin
          pin_sel_r[p] <= pwdata[AAA_ALM_IDX_W-1:0]; // [R8]
        end
      end
    end
  end

  assign gpio_supply_sel = ctrl_r[AAA_CTRL_SUPPLY_BIT]; // [R1]

  // Pad inputs: three stages, a change is taken once stages two and three agree
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      gp_in_r <= '0;
    end
    else
    begin
      sync1_r <= gpio_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int p = 0; p < NUM_PIN; p++)
      begin
        if (sync2_r[p] == sync3_r[p])
        begin
          gp_in_r[p] <= sync3_r[p];
        end
      end
    end
  end

  // Pin value and drive; the Alert pin overrides whatever mode the pin has
  always_comb
  begin
    logic [AAA_ALM_IDX_W-1:0] sel;
    aaa_mode_t mode;
    int s;
    sel = '0;
    mode = AAA_MODE_IN;
    s = 0;
    for (int p = 0; p < NUM_PIN; p++)
    begin
      mode = aaa_mode_t'(pin_mode_r[2*p +: 2]);
      sel = pin_sel_r[p];
      s = int'(sel);
      pin_val[p] = 1'b0;
      pin_drv[p] = 1'b0;
      if (ctrl_r[AAA_CTRL_ALERT_EN_BIT] &&
          (ctrl_r[AAA_CTRL_ALERT_PIN_LSB +: AAA_PIN_IDX_W] == AAA_PIN_IDX_W'(p)))
      begin
        pin_val[p] = alert_raw ^ ctrl_r[AAA_CTRL_ALERT_INV_BIT]; // [R10] [R22]
        pin_drv[p] = 1'b1;
      end
      else if (mode == AAA_MODE_OUT)
      begin
        pin_val[p] = gp_out_r[p];
        pin_drv[p] = 1'b1;
      end
      else if (mode == AAA_MODE_ALARM)
      begin
        // Out-of-range selections show no alarm
        if (s < NUM_ALM)
        begin
          if (is_sticky_kind(s))
          begin
            pin_val[p] = gen_en && (sticky_r[s] || blk_sticky_r[blk_of(s)]); // [R8] [R16]
          end
          else
          begin
            pin_val[p] = live_r[s]; // [R8]
          end
        end
        pin_val[p] = pin_val[p] ^ pin_inv_r[p]; // [R8]
        pin_drv[p] = 1'b1;
      end
      // Open-drain only pulls low and releases for high [R3]
      gpio_oe_nxt[p] = pin_en_r[p] && pin_drv[p] && (!pin_od_r[p] || !pin_val[p]); // [R2] [R3]
      gpio_o_nxt[p] = pin_od_r[p] ? 1'b0 : pin_val[p];
    end
  end

  // Pin outputs registered so the pads see no decode glitches; a pin negates
  // within two cycles of the last clear, far inside the time hosts must allow [R18]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpio_o <= '0;
      gpio_oe <= '0;
    end
    else
    begin
      gpio_o <= gpio_o_nxt;
      gpio_oe <= gpio_oe_nxt;
    end
  end

  // Read decode; clear registers read as zero, unmapped addresses error
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == AAA_OFF_CTRL)
      rd_nxt = ctrl_r;
    else if (paddr == AAA_OFF_LIVE)
      rd_nxt[NUM_ALM-1:0] = live_r; // [R5]
    else if (paddr == AAA_OFF_STICKY)
      rd_nxt[NUM_ALM-1:0] = sticky_r; // [R13]
    else if (paddr == AAA_OFF_STICKY_CLR || paddr == AAA_OFF_BLK_CLR)
      rd_nxt = 32'h0000_0000;
    else if (paddr == AAA_OFF_CONTRIB)
      rd_nxt[NUM_ALM-1:0] = contrib_r;
    else if (paddr == AAA_OFF_BLK_STICKY)
      rd_nxt[NUM_BLK-1:0] = blk_sticky_r; // [R15]
    else if (paddr == AAA_OFF_BLK_EN)
      rd_nxt[NUM_BLK-1:0] = blk_en_r;
    else if (paddr == AAA_OFF_PIN_EN)
      rd_nxt[NUM_PIN-1:0] = pin_en_r;
    else if (paddr == AAA_OFF_PIN_OD)
      rd_nxt[NUM_PIN-1:0] = pin_od_r;
    else if (paddr == AAA_OFF_PIN_PULL)
      rd_nxt[NUM_PIN-1:0] = gpio_pullup;
    else if (paddr == AAA_OFF_PIN_INV)
      rd_nxt[NUM_PIN-1:0] = pin_inv_r;
    else if (paddr == AAA_OFF_PIN_MODE)
      rd_nxt[2*NUM_PIN-1:0] = pin_mode_r;
    else if (paddr == AAA_OFF_GP_OUT)
      rd_nxt[NUM_PIN-1:0] = gp_out_r;
    else if (paddr == AAA_OFF_GP_IN)
      rd_nxt[NUM_PIN-1:0] = gp_in_r;
    else if (paddr == AAA_OFF_PLL_STATE)
      rd_nxt[NUM_PLL*AAA_PLL_ST_W-1:0] = pll_state; // [R15]
    else
    begin
      hit = 1'b0;
      for (int p = 0; p < NUM_PIN; p++)
      begin
        if (paddr == AAA_OFF_PIN_SEL0 + 12'(4 * p))
        begin
          rd_nxt[AAA_ALM_IDX_W-1:0] = pin_sel_r[p];
          hit = 1'b1;
        end
      end
    end
  end

  // APB answer: one wait state, ready and data from flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !hit;
      prdata_r <= rd_en ? rd_nxt : 32'h0000_0000;
    end
  end
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // Checks on the alarm path and the pin drivers
  logic stclr_hit;
  assign stclr_hit = wr_hit(AAA_OFF_STICKY_CLR);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_sticky_on_change: assert property ( // [R6]
    gen_en && (alm_chg != '0) |=> ((sticky_r & $past(alm_chg)) == $past(alm_chg)))
    else $error("sticky bit missed a live change");
  chk_sticky_no_self: assert property ( // [R7]
    !stclr_hit |=> ((sticky_r & $past(sticky_r)) == $past(sticky_r)))
    else $error("sticky bit cleared without a clear write");
  chk_global_gate: assert property ( // [R19]
    !gen_en |=> ((sticky_r & ~$past(sticky_r)) == '0))
    else $error("sticky bit set while alarms disabled");
  chk_holdover_live: assert property ( // [R11]
    (pll_state[AAA_PLL_ST_W-1:0] == AAA_PLL_ST_HOLDOVER) |=> live_r[REF_ALMS])
    else $error("holdover live bit not asserted");
  chk_locked_live: assert property ( // [R12]
    !sys_apll_locked |=> !live_r[REF_ALMS+1])
    else $error("locked live bit without analog loop lock");
  chk_alert_sticky: assert property ( // [R9]
    (sticky_r == '0) && (blk_sticky_r == '0) |=> !alert_raw_r)
    else $error("alert raised without sticky bits");
  chk_alert_or: assert property ( // [R22]
    gen_en && ((sticky_r & contrib_r) != '0) |=> alert_raw_r)
    else $error("enabled sticky bit failed to raise alert");
  chk_block_follow: assert property ( // [R16]
    sticky_r[1] |=> blk_sticky_r[0] [*2])
    else $error("block sticky bit dropped while alarm sticky pending");
  chk_od_no_high: assert property ( // [R3]
    ((gpio_o & gpio_oe & $past(pin_od_r)) == '0))
    else $error("open-drain pin drove high");
  chk_pin_disabled: assert property ( // [R2]
    ((gpio_oe & ~$past(pin_en_r)) == '0))
    else $error("disabled pin is driving");
endmodule

/* File: dv/aaa_host_model.sv */
// Host model: an APB master that issues single-word transfers to the aggregator.
// Assumes the caller starts transfers only after reset has been released.
`timescale 1ns/1ps
module aaa_host_model (
  input wire logic clk, // Block clock
  output logic [11:0] paddr, // Byte address
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // High for write
  output logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error response
  output logic hung // A transfer never completed
);
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // One transfer; everything holds until pready is seen or 20 wait cycles pass, then the bus is released.
  // Released write data is inverted so stale values are never mistaken for new ones.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    q = prdata;
    e = pslverr;
    hung = (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

/* File: dv/alarm_alert_aggregator_tb_top.sv */
// Testbench: register-level scenarios for alarm capture, pins and the Alert output.
// Assumes the core's default sizes: 4 monitors, 3 loops, 8 pins.
`timescale 1ns/1ps
module alarm_alert_aggregator_tb_top
  import aaa_pkg::*;
;
  logic clk;
  logic rstn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ref_freq_alm;
  logic [3:0] ref_los_alm;
  logic [3:0] ref_act_alm;
  logic [11:0] pll_state;
  logic sys_apll_locked;
  logic [7:0] gpio_i;
  logic [7:0] gpio_o;
  logic [7:0] gpio_oe;
  logic [7:0] gpio_pullup;
  logic gpio_supply_sel;
  int failures;
  int checks;

  aaa_core dut_u (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_freq_alm(ref_freq_alm), .ref_los_alm(ref_los_alm), .ref_act_alm(ref_act_alm),
    .pll_state(pll_state), .sys_apll_locked(sys_apll_locked), .gpio_i(gpio_i),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_pullup(gpio_pullup),
    .gpio_supply_sel(gpio_supply_sel));

  aaa_host_model host_u (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hung());

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus access; a hung transfer counts as a mismatch and ends the run
  task automatic io(input logic [11:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    host_u.xfer(a, w, d, q, e);
    if (host_u.hung === 1'b1)
    begin
      failures++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    io(a, 1'b1, d, q, e);
  endtask

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    io(a, 1'b0, 32'h0000_0000, q, e);
    cmp(what, exp, q);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Alarm bits first, block bits after, so nothing re-arms the block bits
  task automatic clr_all();
    wr(AAA_OFF_STICKY_CLR, 32'hFFFF_FFFF);
    wr(AAA_OFF_BLK_CLR, 32'h0000_00FF);
  endtask

  task automatic done(input string name);
    $display("test %s finished, failures so far %0d", name, failures);
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    ref_freq_alm = 4'h0;
    ref_los_alm = 4'h0;
    ref_act_alm = 4'h0;
    pll_state = 12'h000;
    sys_apll_locked = 1'b0;
    gpio_i = 8'h00;
    failures = 0;
    checks = 0;
    tick(6);
    rstn <= 1'b1;
    // Reset state and global pin settings
    rdc("ctrl", AAA_OFF_CTRL, AAA_CTRL_RST);
    cmp("pullup", 32'h0000_00FF, 32'(gpio_pullup));
    rdc("pin_pull", AAA_OFF_PIN_PULL, 32'h0000_00FF);
    wr(AAA_OFF_PIN_PULL, 32'h0000_000F);
    tick(2);
    cmp("pullup", 32'h0000_000F, 32'(gpio_pullup));
    cmp("supply", 32'h0000_0000, 32'(gpio_supply_sel));
    wr(AAA_OFF_CTRL, 32'h0000_0002);
    tick(2);
    cmp("supply", 32'h0000_0001, 32'(gpio_supply_sel));
    done("reset");
    // Global enable off: live follows, nothing sticks
    ref_los_alm <= 4'h1;
    tick(3);
    rdc("live", AAA_OFF_LIVE, 32'h0000_0002);
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_0000);
    ref_los_alm <= 4'h0;
    tick(3);
    wr(AAA_OFF_CTRL, 32'h0000_0003);
    done("gate");
    // Sticky capture on both edges, selective clears
    ref_los_alm <= 4'h1;
    tick(3);
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_0002);
    rdc("blk", AAA_OFF_BLK_STICKY, 32'h0000_0001);
    wr(AAA_OFF_STICKY_CLR, 32'h0000_0002);
    tick(3);
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_0000);
    ref_los_alm <= 4'h0;
    tick(3);
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_0002);
    rdc("live", AAA_OFF_LIVE, 32'h0000_0000);
    ref_freq_alm <= 4'h2;
    ref_act_alm <= 4'h4;
    tick(3);
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_010A);
    wr(AAA_OFF_STICKY_CLR, 32'h0000_0008);
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_0102);
    ref_freq_alm <= 4'h0;
    ref_act_alm <= 4'h0;
    tick(3);
    clr_all();
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_0000);
    rdc("blk", AAA_OFF_BLK_STICKY, 32'h0000_0000);
    done("sticky");
    // Loop states drive holdover and locked alarms
    pll_state <= {8'h00, AAA_PLL_ST_HOLDOVER};
    tick(3);
    rdc("live", AAA_OFF_LIVE, 32'h0000_1000);
    rdc("sticky", AAA_OFF_STICKY, 32'h0000_1000);
    rdc("state", AAA_OFF_PLL_STATE, 32'h0000_0005);
    pll_state <= {8'h00, AAA_PLL_ST_LOCKED};
    tick(3);
    rdc("live", AAA_OFF_LIVE, 32'h0000_0000);
    sys_apll_locked <= 1'b1;
    tick(3);
    rdc("live", AAA_OFF_LIVE, 32'h0000_2000);
    pll_state <= {AAA_PLL_ST_HOLDOVER, 4'h0, AAA_PLL_ST_LOCKED};
    tick(3);
    rdc("live", AAA_OFF_LIVE, 32'h0001_2000);
    sys_apll_locked <= 1'b0;
    pll_state <= 12'h000;
    tick(3);
    clr_all();
    done("loops");
    // Alarm pin 3 follows loop 0 holdover, sticky until both levels clear
    wr(AAA_OFF_PIN_MODE, 32'h0000_0080);
    wr(AAA_OFF_PIN_SEL0 + 12'h00C, 32'h0000_000C);
    wr(AAA_OFF_PIN_EN, 32'h0000_0008);
    pll_state <= {8'h00, AAA_PLL_ST_HOLDOVER};
    tick(4);
    cmp("pin3", 32'h0000_0001, 32'(gpio_o[3]));
    wr(AAA_OFF_STICKY_CLR, 32'h0000_1000);
    tick(4);
    cmp("pin3", 32'h0000_0001, 32'(gpio_o[3]));
    wr(AAA_OFF_BLK_CLR, 32'h0000_0010);
    tick(4);
    cmp("pin3", 32'h0000_0000, 32'(gpio_o[3]));
    cmp("oe3", 32'h0000_0001, 32'(gpio_oe[3]));
    wr(AAA_OFF_PIN_INV, 32'h0000_0008);
    tick(4);
    cmp("pin3", 32'h0000_0001, 32'(gpio_o[3]));
    wr(AAA_OFF_PIN_OD, 32'h0000_0008);
    tick(4);
    cmp("pin3", 32'h0000_0000, 32'(gpio_o[3]));
    cmp("oe3", 32'h0000_0000, 32'(gpio_oe[3]));
    wr(AAA_OFF_PIN_INV, 32'h0000_0000);
    tick(4);
    cmp("oe3", 32'h0000_0001, 32'(gpio_oe[3]));
    wr(AAA_OFF_PIN_EN, 32'h0000_0000);
    tick(4);
    cmp("oe3", 32'h0000_0000, 32'(gpio_oe[3]));
    pll_state <= 12'h000;
    tick(3);
    clr_all();
    done("alarm_pin");
    // Alert on pin 2 from enabled sticky bits only
    wr(AAA_OFF_CONTRIB, 32'h0000_0002);
    wr(AAA_OFF_BLK_EN, 32'h0000_0000);
    wr(AAA_OFF_PIN_EN, 32'h0000_0004);
    wr(AAA_OFF_CTRL, 32'h0000_020B);
    tick(4);
    cmp("alert", 32'h0000_0000, 32'(gpio_o[2]));
    ref_los_alm <= 4'h1;
    tick(1);
    ref_los_alm <= 4'h0;
    tick(4);
    cmp("alert", 32'h0000_0001, 32'(gpio_o[2]));
    wr(AAA_OFF_STICKY_CLR, 32'h0000_0002);
    tick(4);
    cmp("alert", 32'h0000_0000, 32'(gpio_o[2]));
    wr(AAA_OFF_BLK_EN, 32'h0000_0001);
    tick(4);
    cmp("alert", 32'h0000_0001, 32'(gpio_o[2]));
    wr(AAA_OFF_BLK_CLR, 32'h0000_0001);
    tick(4);
    cmp("alert", 32'h0000_0000, 32'(gpio_o[2]));
    wr(AAA_OFF_CTRL, 32'h0000_020F);
    tick(4);
    cmp("alert", 32'h0000_0001, 32'(gpio_o[2]));
    done("alert");
    // General purpose output and input, unmapped access
    wr(AAA_OFF_PIN_MODE, 32'h0000_0001);
    wr(AAA_OFF_GP_OUT, 32'h0000_0001);
    wr(AAA_OFF_PIN_EN, 32'h0000_0001);
    gpio_i <= 8'h20;
    tick(6);
    cmp("gp_o", 32'h0000_0001, 32'({gpio_oe[0], gpio_o[0]}) >> 0 & 32'h1);
    cmp("gp_oe", 32'h0000_0001, 32'(gpio_oe[0]));
    rdc("gp_in", AAA_OFF_GP_IN, 32'h0000_0020);
    rdc("clr_rd", AAA_OFF_STICKY_CLR, 32'h0000_0000);
    begin
      logic [31:0] q;
      logic e;
      io(12'hFFC, 1'b0, 32'h0000_0000, q, e);
      cmp("slverr", 32'h0000_0001, 32'(e));
      cmp("unmapped", 32'h0000_0000, q);
    end
    done("gp");
    stop_test();
  end
endmodule
